// file: hdl/dspm_pin_mux.sv
// Pin sharing of three port C pins among quadrature decoder, timer B, SPI 1 and GPIO.
module dspm_pin_mux
  import dspm_pkg::*;
#(
  parameter bit FULL_VARIANT = 1'b1
)
(
  input  wire logic                clk_sys,
  input  wire logic                sys_rst,
  // Pads.
  input  wire logic [NUM_PINS-1:0] pad_in,
  output logic      [NUM_PINS-1:0] pad_out,
  output logic      [NUM_PINS-1:0] pad_oe,
  output logic      [NUM_PINS-1:0] pad_pullup_en,
  // Configuration writes.
  input  wire logic                pin_sel_wr_en,
  input  wire logic [NUM_PINS-1:0] pin_sel_wr_data,
  input  wire logic                pullup_wr_en,
  input  wire logic [NUM_PINS-1:0] pullup_wr_data,
  input  wire logic                gpio_en_wr_en,
  input  wire logic [NUM_PINS-1:0] gpio_en_wr_data,
  input  wire logic                gpio_dir_wr_en,
  input  wire logic [NUM_PINS-1:0] gpio_dir_wr_data,
  input  wire logic                gpio_out_wr_en,
  input  wire logic [NUM_PINS-1:0] gpio_out_wr_data,
  // Configuration readback.
  output logic [NUM_PINS-1:0]      system_pin_select_reg,
  output logic [NUM_PINS-1:0]      port_c_pullup_reg,
  output logic [NUM_PINS-1:0]      gpio_enable_reg,
  output logic [NUM_PINS-1:0]      gpio_direction_reg,
  output logic [NUM_PINS-1:0]      gpio_output_reg,
  output logic [NUM_PINS-1:0]      pin_configured,
  // Decoder side.
  output logic                     decoder_phase_a_in,
  output logic                     decoder_phase_b_in,
  output logic                     decoder_index_in,
  // Timer B channels 0 to 2.
  input  wire logic [NUM_PINS-1:0] timer_b_out,
  input  wire logic [NUM_PINS-1:0] timer_b_oe,
  output logic                     timer_b_chan_zero,
  output logic                     timer_b_chan_one,
  output logic                     timer_b_chan_two,
  // SPI 1.
  input  wire logic                spi_master,
  input  wire logic                spi_slave_selected,
  input  wire logic                spi_sclk_out,
  input  wire logic                spi_mosi_out,
  input  wire logic                spi_miso_out,
  output logic                     spi_sclk_in,
  output logic                     spi_mosi_in,
  output logic                     spi_miso_in,
  // GPIO readback of the pad levels.
  output logic                     port_c_bit_zero,
  output logic                     port_c_bit_one,
  output logic                     port_c_bit_two
);

  localparam logic [NUM_PINS-1:0] CONFIGURED_RST = FULL_VARIANT ? ALL_PINS : NO_PINS;

  // Configuration state.
  logic [NUM_PINS-1:0] pin_sel_q,  pin_sel_d;
  logic [NUM_PINS-1:0] pullup_q,   pullup_d;
  logic [NUM_PINS-1:0] gpio_en_q,  gpio_en_d;
  logic [NUM_PINS-1:0] gpio_dir_q, gpio_dir_d;
  logic [NUM_PINS-1:0] gpio_out_q, gpio_out_d;
  logic [NUM_PINS-1:0] cfg_ok_q,   cfg_ok_d;

  // Pad and peripheral-facing state.
  logic [NUM_PINS-1:0] pad_out_q,  pad_out_d;
  logic [NUM_PINS-1:0] pad_oe_q,   pad_oe_d;
  logic [NUM_PINS-1:0] dec_q,      dec_d;
  logic [NUM_PINS-1:0] tmr_q,      tmr_d;
  logic [NUM_PINS-1:0] spi_q,      spi_d;
  logic [NUM_PINS-1:0] gpio_in_q,  gpio_in_d;

  logic [NUM_PINS-1:0] pad_sync;
  logic [NUM_PINS-1:0] spi_out_vec;
  logic [NUM_PINS-1:0] spi_oe_vec;
  dspm_mode_t          mode [NUM_PINS];

  dspm_sync u_sync (
    .clk_sys  (clk_sys),
    .sys_rst  (sys_rst),
    .async_in (pad_in),
    .sync_out (pad_sync)
  );

  always_comb begin
    pin_sel_d  = pin_sel_q;
    pullup_d   = pullup_q;
    gpio_en_d  = gpio_en_q;
    gpio_dir_d = gpio_dir_q;
    gpio_out_d = gpio_out_q;
    cfg_ok_d   = cfg_ok_q;
    if (pin_sel_wr_en) begin
      pin_sel_d = pin_sel_wr_data;
    end
    if (pullup_wr_en) begin
      pullup_d = pullup_wr_data;
    end
    if (gpio_en_wr_en) begin
      gpio_en_d = gpio_en_wr_data;
    end
    if (gpio_dir_wr_en) begin
      gpio_dir_d = gpio_dir_wr_data;
    end
    if (gpio_out_wr_en) begin
      gpio_out_d = gpio_out_wr_data;
    end
    // Any write to the selection or the GPIO enable gives every pin a function.
    if (pin_sel_wr_en || gpio_en_wr_en) begin
      cfg_ok_d = ALL_PINS;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      pin_sel_q  <= PIN_SEL_RST;
      pullup_q   <= PULLUP_RST;
      gpio_en_q  <= GPIO_EN_RST;
      gpio_dir_q <= GPIO_DIR_RST;
      gpio_out_q <= GPIO_OUT_RST;
      cfg_ok_q   <= CONFIGURED_RST;
    end else begin
      pin_sel_q  <= pin_sel_d;
      pullup_q   <= pullup_d;
      gpio_en_q  <= gpio_en_d;
      gpio_dir_q <= gpio_dir_d;
      gpio_out_q <= gpio_out_d;
      cfg_ok_q   <= cfg_ok_d;
    end
  end

  // Per-pin function: GPIO enable wins over the alternate select.
  for (genvar i = 0; i < NUM_PINS; i++) begin : g_mode
    always_comb begin
      if (!cfg_ok_q[i]) begin
        mode[i] = MODE_NONE;
      end else if (gpio_en_q[i]) begin
        mode[i] = MODE_GPIO;
      end else if (pin_sel_q[i]) begin
        mode[i] = MODE_SPI;
      end else begin
        mode[i] = MODE_QDEC;
      end
    end
  end

  // SPI 1 signal and drive direction for each pin position.
  always_comb begin
    spi_out_vec[PIN_PHASE_A] = spi_sclk_out;
    spi_out_vec[PIN_PHASE_B] = spi_mosi_out;
    spi_out_vec[PIN_INDEX]   = spi_miso_out;
    spi_oe_vec[PIN_PHASE_A]  = spi_master;
    spi_oe_vec[PIN_PHASE_B]  = spi_master;
    spi_oe_vec[PIN_INDEX]    = !spi_master && spi_slave_selected;
  end

  always_comb begin
    pad_out_d = NO_PINS;
    pad_oe_d  = NO_PINS;
    dec_d     = dec_q;
    tmr_d     = tmr_q;
    spi_d     = spi_q;
    gpio_in_d = pad_sync;
    for (int i = 0; i < NUM_PINS; i++) begin
      unique case (mode[i])
        MODE_NONE: begin
          pad_oe_d[i] = 1'b0;
        end
        MODE_QDEC: begin
          dec_d[i]     = pad_sync[i];
          tmr_d[i]     = pad_sync[i];
          pad_out_d[i] = timer_b_out[i];
          pad_oe_d[i]  = timer_b_oe[i];
        end
        MODE_SPI: begin
          // Outputs of every SPI pin see the same one-cycle register delay, so the
          // half-clock lead of data over the sampling edge is kept intact.
          pad_out_d[i] = spi_out_vec[i];
          pad_oe_d[i]  = spi_oe_vec[i];
          spi_d[i]     = pad_sync[i];
        end
        MODE_GPIO: begin
          pad_out_d[i] = gpio_out_q[i];
          pad_oe_d[i]  = gpio_dir_q[i];
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      pad_out_q <= NO_PINS;
      pad_oe_q  <= NO_PINS;
      dec_q     <= DEC_IDLE_RST;
      tmr_q     <= DEC_IDLE_RST;
      spi_q     <= DEC_IDLE_RST;
      gpio_in_q <= DEC_IDLE_RST;
    end else begin
      pad_out_q <= pad_out_d;
      pad_oe_q  <= pad_oe_d;
      dec_q     <= dec_d;
      tmr_q     <= tmr_d;
      spi_q     <= spi_d;
      gpio_in_q <= gpio_in_d;
    end
  end

  assign pad_out       = pad_out_q;
  assign pad_oe        = pad_oe_q;
  assign pad_pullup_en = pullup_q;

  assign system_pin_select_reg = pin_sel_q;
  assign port_c_pullup_reg     = pullup_q;
  assign gpio_enable_reg       = gpio_en_q;
  assign gpio_direction_reg    = gpio_dir_q;
  assign gpio_output_reg       = gpio_out_q;
  assign pin_configured        = cfg_ok_q;

  assign decoder_phase_a_in = dec_q[PIN_PHASE_A];
  assign decoder_phase_b_in = dec_q[PIN_PHASE_B];
  assign decoder_index_in   = dec_q[PIN_INDEX];

  assign timer_b_chan_zero = tmr_q[PIN_PHASE_A];
  assign timer_b_chan_one  = tmr_q[PIN_PHASE_B];
  assign timer_b_chan_two  = tmr_q[PIN_INDEX];

  assign spi_sclk_in = spi_q[PIN_PHASE_A];
  assign spi_mosi_in = spi_q[PIN_PHASE_B];
  assign spi_miso_in = spi_q[PIN_INDEX];

  assign port_c_bit_zero = gpio_in_q[PIN_PHASE_A];
  assign port_c_bit_one  = gpio_in_q[PIN_PHASE_B];
  assign port_c_bit_two  = gpio_in_q[PIN_INDEX];

endmodule : dspm_pin_mux

// file: include/dspm_pkg.sv
// Constants, field positions, reset values and pin modes for the decoder/SPI pin mux.
package dspm_pkg;

  localparam int unsigned NUM_PINS    = 3;
  localparam int unsigned PIN_PHASE_A = 0;
  localparam int unsigned PIN_PHASE_B = 1;
  localparam int unsigned PIN_INDEX   = 2;

  localparam logic [2:0] PIN_SEL_RST   = 3'h0;
  localparam logic [2:0] PULLUP_RST    = 3'h7;
  localparam logic [2:0] GPIO_EN_RST   = 3'h0;
  localparam logic [2:0] GPIO_DIR_RST  = 3'h0;
  localparam logic [2:0] GPIO_OUT_RST  = 3'h0;
  localparam logic [2:0] ALL_PINS      = 3'h7;
  localparam logic [2:0] NO_PINS       = 3'h0;
  localparam logic [2:0] DEC_IDLE_RST  = 3'h7;

  typedef enum logic [1:0] {
    MODE_NONE,
    MODE_QDEC,
    MODE_SPI,
    MODE_GPIO
  } dspm_mode_t;

endpackage : dspm_pkg

// file: hdl/dspm_sync.sv
// Two-flop synchroniser for the pad inputs, one stage pair per bit.
module dspm_sync
  import dspm_pkg::*;
(
  input  wire logic                clk_sys,
  input  wire logic                sys_rst,
  input  wire logic [NUM_PINS-1:0] async_in,
  output logic      [NUM_PINS-1:0] sync_out
);

  for (genvar i = 0; i < NUM_PINS; i++) begin : g_bit
    logic meta_q;
    logic sync_q;

    always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
        meta_q <= 1'b1;
        sync_q <= 1'b1;
      end else begin
        meta_q <= async_in[i];
        sync_q <= meta_q;
      end
    end

    assign sync_out[i] = sync_q;
  end

endmodule : dspm_sync

// file: tb/dspm_pin_mux_assertions.sv
// Concurrent checks on the ports of the decoder/SPI pin mux.
module dspm_pin_mux_assertions (
  input wire logic       clk_sys,
  input wire logic       sys_rst,
  input wire logic [2:0] pad_in,
  input wire logic [2:0] pad_out,
  input wire logic [2:0] pad_oe,
  input wire logic       pin_sel_wr_en,
  input wire logic [2:0] pin_sel_wr_data,
  input wire logic       pullup_wr_en,
  input wire logic [2:0] pullup_wr_data,
  input wire logic [2:0] system_pin_select_reg,
  input wire logic [2:0] port_c_pullup_reg,
  input wire logic [2:0] gpio_enable_reg,
  input wire logic [2:0] gpio_direction_reg,
  input wire logic [2:0] pin_configured,
  input wire logic [2:0] timer_b_oe,
  input wire logic       spi_master,
  input wire logic       spi_slave_selected,
  input wire logic       spi_sclk_out,
  input wire logic       port_c_bit_zero,
  input wire logic       port_c_bit_one,
  input wire logic       port_c_bit_two
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);
  logic [1:0] rc_q;
  logic [1:0] rc_d;
  wire logic [2:0] gp = gpio_enable_reg & pin_configured;
  wire logic [2:0] sp = system_pin_select_reg & pin_configured & ~gpio_enable_reg;
  wire logic [2:0] dm = pin_configured & ~gpio_enable_reg & ~system_pin_select_reg;
  // Counts edges since reset so the three-stage input path is only judged once filled.
  always_comb rc_d = (rc_q == 2'h3) ? rc_q : rc_q + 2'h1;
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) rc_q <= 2'h0;
    else rc_q <= rc_d;
  end
  sel_write_a: assert property (
    pin_sel_wr_en |=> system_pin_select_reg == $past(pin_sel_wr_data))
    else $error("select write lost");
  pullup_write_a: assert property (
    pullup_wr_en |=> port_c_pullup_reg == $past(pullup_wr_data))
    else $error("pull-up write lost");
  spi_clock_a: assert property (
    sp[0] |=> pad_oe[0] == $past(spi_master) && pad_out[0] == $past(spi_sclk_out))
    else $error("clock pin drive wrong");
  mosi_dir_a: assert property (sp[1] |=> pad_oe[1] == $past(spi_master))
    else $error("mosi direction wrong");
  miso_dir_a: assert property (
    sp[2] |=> pad_oe[2] == $past(!spi_master && spi_slave_selected))
    else $error("miso direction wrong");
  gpio_dir_a: assert property (
    |gp |=> (pad_oe & $past(gp)) == $past(gpio_direction_reg & gp))
    else $error("gpio direction wrong");
  decoder_drive_a: assert property (
    |dm |=> (pad_oe & $past(dm)) == $past(timer_b_oe & dm))
    else $error("timer drive wrong");
  unconf_float_a: assert property (
    |(~pin_configured) |=> (pad_oe & $past(~pin_configured)) == 3'h0)
    else $error("unconfigured pin driven");
  input_path_a: assert property (
    rc_q == 2'h3 |-> {port_c_bit_two, port_c_bit_one, port_c_bit_zero} == $past(pad_in, 3))
    else $error("pad level not passed on");
  cover property (sp[2] && spi_slave_selected && !spi_master);
  cover property (|gp);
  cover property (pullup_wr_en);
  cover property (|(~pin_configured) && |timer_b_oe);
endmodule : dspm_pin_mux_assertions

bind dspm_pin_mux dspm_pin_mux_assertions u_chk (.*);

// file: tb/dspm_periph.sv
// Behavioural model of the timer B and SPI 1 drivers beside the mux.
module dspm_periph (
  input  wire logic       clk_sys,
  input  wire logic       run,
  output logic      [2:0] timer_b_out,
  output logic      [2:0] timer_b_oe,
  output logic            spi_sclk_out,
  output logic            spi_mosi_out,
  output logic            spi_miso_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [5:0] cnt_q = 6'h00;
  always @(posedge clk_sys) if (run) cnt_q <= cnt_q + 6'h01;
  // Data bits change only when the clock bit falls, so they lead its rising edge by half a period.
  assign spi_sclk_out = cnt_q[0];
  assign spi_mosi_out = cnt_q[1];
  assign spi_miso_out = cnt_q[2];
  assign timer_b_out  = cnt_q[2:0];
  assign timer_b_oe   = cnt_q[5:3];
endmodule : dspm_periph

// file: tb/tb_dspm_pin_mux.sv
// Self-checking bench for the decoder/SPI pin mux.
module tb_dspm_pin_mux;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0, sys_rst = 1'b1, run = 1'b0, spi_master = 1'b0, spi_slave_selected = 1'b0;
  logic pin_sel_wr_en = 1'b0, pullup_wr_en = 1'b0, gpio_en_wr_en = 1'b0;
  logic gpio_dir_wr_en = 1'b0, gpio_out_wr_en = 1'b0;
  logic [2:0] pin_sel_wr_data = 3'h0, pullup_wr_data = 3'h0, gpio_en_wr_data = 3'h0;
  logic [2:0] gpio_dir_wr_data = 3'h0, gpio_out_wr_data = 3'h0, board_lvl = 3'h5;
  logic [2:0] pad_in, pad_out, pad_oe, pad_pullup_en, system_pin_select_reg, port_c_pullup_reg;
  logic [2:0] gpio_enable_reg, gpio_direction_reg, gpio_output_reg, pin_configured;
  logic [2:0] timer_b_out, timer_b_oe, exp_in, exp_oe, exp_out, sel;
  logic [2:0] red_oe, red_cfg;
  logic decoder_phase_a_in, decoder_phase_b_in, decoder_index_in;
  logic timer_b_chan_zero, timer_b_chan_one, timer_b_chan_two;
  logic spi_sclk_out, spi_mosi_out, spi_miso_out, spi_sclk_in, spi_mosi_in, spi_miso_in;
  logic port_c_bit_zero, port_c_bit_one, port_c_bit_two;
  int err_total = 0, checked = 0, cyc = 0;
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & board_lvl);
  dspm_pin_mux uut (.*);
  dspm_periph u_per (.*);
  // Reduced variant beside the full one: same stimulus, only its drive and function bits watched.
  dspm_pin_mux #(.FULL_VARIANT(1'b0)) u_red (
    .*,
    .pad_out               (),
    .pad_oe                (red_oe),
    .pad_pullup_en         (),
    .system_pin_select_reg (),
    .port_c_pullup_reg     (),
    .gpio_enable_reg       (),
    .gpio_direction_reg    (),
    .gpio_output_reg       (),
    .pin_configured        (red_cfg),
    .decoder_phase_a_in    (),
    .decoder_phase_b_in    (),
    .decoder_index_in      (),
    .timer_b_chan_zero     (),
    .timer_b_chan_one      (),
    .timer_b_chan_two      (),
    .spi_sclk_in           (),
    .spi_mosi_in           (),
    .spi_miso_in           (),
    .port_c_bit_zero       (),
    .port_c_bit_one        (),
    .port_c_bit_two        ()
  );
  always #25 clk_sys = ~clk_sys;
  task automatic tk(input int n);
    repeat (n) @(posedge clk_sys);
    #5;
  endtask : tk
  task automatic wr(ref logic e, ref logic [2:0] d, input logic [2:0] v);
    e = 1'b1;
    d = v;
    tk(1);
    e = 1'b0;
  endtask : wr
  task automatic chk(input string n, input logic [2:0] s, input logic [2:0] e);
    checked++;
    if (s !== e) begin
      err_total++;
      $display("BAD %s exp %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic test_done();
    if (err_total == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : test_done
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      test_done();
    end
  end
  initial begin
    tk(12);
    sys_rst = 1'b0;
    tk(1);
    chk("cfg", pin_configured, 3'h7);
    chk("pullup", pad_pullup_en, 3'h7);
    chk("red_cfg", red_cfg, 3'h0);
    for (int i = 0; i < 4; i++) begin
      board_lvl = board_lvl ^ 3'h3;
      run = 1'b1;
      tk(7);
      run = 1'b0;
      tk(4);
      exp_in = (timer_b_oe & timer_b_out) | (~timer_b_oe & board_lvl);
      chk("dec_oe", pad_oe, timer_b_oe);
      chk("red_oe", red_oe, 3'h0);
      chk("dec_in", {decoder_index_in, decoder_phase_b_in, decoder_phase_a_in}, exp_in);
      chk("tmr_in", {timer_b_chan_two, timer_b_chan_one, timer_b_chan_zero}, exp_in);
    end
    for (int s = 1; s < 8; s++) begin
      sel = s[2:0];
      wr(pin_sel_wr_en, pin_sel_wr_data, sel);
      for (int m = 0; m < 4; m++) begin
        {spi_master, spi_slave_selected} = m[1:0];
        board_lvl = ~board_lvl;
        run = 1'b1;
        tk(3);
        run = 1'b0;
        tk(4);
        exp_oe = {~spi_master & spi_slave_selected, spi_master, spi_master};
        exp_oe = (sel & exp_oe) | (~sel & timer_b_oe);
        exp_out = (sel & {spi_miso_out, spi_mosi_out, spi_sclk_out}) | (~sel & timer_b_out);
        exp_in = (exp_oe & exp_out) | (~exp_oe & board_lvl);
        chk("sel", system_pin_select_reg, sel);
        chk("red_cfg", red_cfg, 3'h7);
        chk("spi_oe", pad_oe, exp_oe);
        chk("spi_out", pad_out & exp_oe, exp_out & exp_oe);
        chk("spi_in", {spi_miso_in, spi_mosi_in, spi_sclk_in} & sel, exp_in & sel);
      end
    end
    for (int i = 0; i < 3; i++) begin
      wr(pullup_wr_en, pullup_wr_data, ~(3'h1 << i));
      tk(2);
      chk("pullup", pad_pullup_en, ~(3'h1 << i));
    end
    wr(gpio_dir_wr_en, gpio_dir_wr_data, 3'h5);
    wr(gpio_out_wr_en, gpio_out_wr_data, 3'h3);
    wr(gpio_en_wr_en, gpio_en_wr_data, 3'h7);
    board_lvl = 3'h2;
    tk(5);
    chk("gpio_oe", pad_oe, 3'h5);
    chk("gpio_in", {port_c_bit_two, port_c_bit_one, port_c_bit_zero}, 3'h3);
    chk("gpio_drv", pad_out & pad_oe, 3'h1);
    chk("gpio_dir", gpio_direction_reg, 3'h5);
    chk("gpio_out", gpio_output_reg, 3'h3);
    sys_rst = 1'b1;
    tk(2);
    sys_rst = 1'b0;
    tk(1);
    chk("rst_sel", system_pin_select_reg, 3'h0);
    chk("rst_gpio", gpio_enable_reg, 3'h0);
    chk("rst_pull", port_c_pullup_reg, 3'h7);
    chk("rst_dir", gpio_direction_reg, 3'h0);
    chk("rst_out", gpio_output_reg, 3'h0);
    chk("rst_red", red_cfg, 3'h0);
    test_done();
  end
endmodule : tb_dspm_pin_mux
